// File: cadc_pkg.sv
/*
 * Shared constants and types of the cell conversion sequencer: register
 * offsets, field positions, reset values, mode and timing tables.
 * Assumes a single 40 MHz clock; all times are whole microseconds.
 */
package cadc_pkg;

    typedef int unsigned cadc_tab_t [6];

    localparam int unsigned CLK_HZ     = 40_000_000;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;

    // Mode order: 27k fast, 14k, 7k normal, 3k, 2k, 26 Hz filtered
    localparam cadc_tab_t FIRST_SLOT_US  = '{57, 86, 144, 260, 493, 29817};
    localparam cadc_tab_t SWEEP_MEAS_US  = '{290, 465, 814, 1512, 2908,
                                             178850};
    localparam cadc_tab_t FULL_DONE_US   = '{1113, 1288, 2335, 3033, 4430,
                                             201317};
    localparam cadc_tab_t PAIR_DONE_US   = '{201, 230, 405, 521, 754, 33568};
    // Reference wake time is not fixed by the part; plain default
    localparam int unsigned REF_WAKE_US  = 4400;

    function automatic cadc_tab_t to_cyc(input cadc_tab_t us);
        cadc_tab_t r;
        for (int i = 0; i < 6; i++) begin
            r[i] = us[i] * CYC_PER_US;
        end
        return r;
    endfunction

    localparam cadc_tab_t   FIRST_SLOT_CYC = to_cyc(FIRST_SLOT_US);
    localparam cadc_tab_t   SWEEP_MEAS_CYC = to_cyc(SWEEP_MEAS_US);
    localparam cadc_tab_t   FULL_DONE_CYC  = to_cyc(FULL_DONE_US);
    localparam cadc_tab_t   PAIR_DONE_CYC  = to_cyc(PAIR_DONE_US);
    localparam int unsigned REF_WAKE_CYC   = REF_WAKE_US * CYC_PER_US;
    localparam int unsigned SWEEP_SLOTS    = 6;

    // Register word offsets
    localparam logic [7:0] OFS_CFG      = 8'h00;
    localparam logic [7:0] OFS_UV_THR   = 8'h01;
    localparam logic [7:0] OFS_OV_THR   = 8'h02;
    localparam logic [7:0] OFS_STATUS   = 8'h03;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN   = 8'h05;
    localparam logic [7:0] OFS_IRQ_CLR  = 8'h06;
    localparam logic [7:0] OFS_UV_FLAGS = 8'h07;
    localparam logic [7:0] OFS_OV_FLAGS = 8'h08;
    localparam logic [7:0] OFS_CELL0    = 8'h10;
    localparam logic [7:0] OFS_AUX0     = 8'h20;

    // Field positions
    localparam int CFG_FILTER_BIT = 0;
    localparam int CFG_REF_KEEP_ON_BIT  = 1;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_REF_POWERED_STATE_BIT   = 1;
    localparam int ST_MODE_LSB    = 2;
    localparam int ST_AUX_BIT     = 5;
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_UV_BIT     = 1;
    localparam int IRQ_OV_BIT     = 2;
    localparam int IRQ_REFUSE_BIT = 3;

    // Reset values
    localparam logic [1:0]  CFG_RST    = 2'h0;
    localparam logic [15:0] UV_THR_RST = 16'h0000;
    localparam logic [15:0] OV_THR_RST = 16'hFFFF;
    localparam logic [3:0]  IRQ_EN_RST = 4'h0;

    typedef enum logic [2:0] {
        CADC_M27K  = 3'h0,
        CADC_M14K  = 3'h1,
        CADC_M7K   = 3'h2,
        CADC_M3K   = 3'h3,
        CADC_M2K   = 3'h4,
        CADC_M26HZ = 3'h5
    } cadc_mode_e;

    typedef struct packed {
        logic       aux;      // 0 cell_convert_cmd, 1 aux_convert_cmd
        logic [1:0] mode;     // conv_mode_field
        logic [2:0] chan;     // 0 all, 1..6 single selection
    } cadc_cmd_s;

    typedef struct packed {
        logic       active;
        logic       calibrating;
        logic       aux;
        logic [3:0] chan1;
        logic [3:0] chan2;
        cadc_mode_e mode;
    } cadc_fe_s;

endpackage

// File: cadc_sequencer.sv
/*
 * Conversion sequencer: mode select, reference wake, slot timing, result
 * clamp and storage, threshold flags, register port and interrupt.
 * Assumes commands and converter samples come from logic on clk.
 */
`timescale 1ns/10ps

// Summary of operation
// [RL1] Mode is picked from filter select bit and two-bit command mode field.
// [RL2] Filtered mode lowers the filter corner to 26 Hz with long conversions.
// [RL3] Intermediate modes give 13.5 kHz, 3.4 kHz and 1.7 kHz corners.
// [RL4] From standby, wait the reference wake delay before converting.
// [RL5] With keep-on set, reference stays powered; later commands skip the wait.
// [RL6] Results are 16-bit unsigned codes at 100 uV per step for all inputs.
// [RL7] Negative results are stored as zero.
// [RL8] Cell command selects channel count and conversion mode.
// [RL9] All-cell run: first converter bottom six, second converter top six.
// [RL10] Calibration follows measurements; command completes when it ends.
// [RL11] All-cell done at 1113, 2335, 201317 us for fast, normal, filtered.
// [RL12] Slot lasts 57, 144, 29817 us; first slot timed from command start.
// [RL13] Two-cell run done at 201, 405, 33568 us.
// [RL14] Each cell result compared to thresholds; set over and under flags.
// [RL15] Thresholds come from configuration; flags land in status storage.
// [RL16] Aux command converts one GPIO, second reference, or all six.
// [RL17] All aux measurements run on the first converter alone.
// [RL18] Slots and calibration are timed by a clock-driven counter.
// [RL19] Only selected channels get new results and flags.
module cadc_sequencer #(
    parameter cadc_pkg::cadc_tab_t FIRST_SLOT_CYC = cadc_pkg::FIRST_SLOT_CYC,
    parameter cadc_pkg::cadc_tab_t SWEEP_MEAS_CYC = cadc_pkg::SWEEP_MEAS_CYC,
    parameter cadc_pkg::cadc_tab_t FULL_DONE_CYC  = cadc_pkg::FULL_DONE_CYC,
    parameter cadc_pkg::cadc_tab_t PAIR_DONE_CYC  = cadc_pkg::PAIR_DONE_CYC,
    parameter int unsigned         REF_WAKE_CYC   = cadc_pkg::REF_WAKE_CYC,
    parameter int                  CNT_W          = 24,
    parameter int                  NUM_CELLS      = 12,
    parameter int                  NUM_AUX        = 6
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    input  wire logic               cmd_valid,
    input  wire cadc_pkg::cadc_cmd_s cmd,
    output logic                    cmd_ready,
    input  wire logic signed [16:0] fe_raw1,
    input  wire logic signed [16:0] fe_raw2,
    output cadc_pkg::cadc_fe_s      fe,
    output logic                    ref_power_on,
    output logic                    irq
);

    typedef enum logic [3:0] {
        CADC_IDLE = 4'b0001,
        CADC_WAKE = 4'b0010,
        CADC_MEAS = 4'b0100,
        CADC_CAL  = 4'b1000
    } cadc_state_e;

    ////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic cadc_pkg::cadc_mode_e mode_of(input logic opt,
                                                    input logic [1:0] md);
        unique case (md)
            2'h1:    mode_of = opt ? cadc_pkg::CADC_M14K
                                   : cadc_pkg::CADC_M27K;
            2'h2:    mode_of = opt ? cadc_pkg::CADC_M3K
                                   : cadc_pkg::CADC_M7K;
            2'h3:    mode_of = opt ? cadc_pkg::CADC_M2K
                                   : cadc_pkg::CADC_M26HZ;
            default: mode_of = cadc_pkg::CADC_M7K;
        endcase
    endfunction

    // Negative readings become zero; positive span fits in 16 bits
    function automatic logic [15:0] clamp(input logic signed [16:0] raw);
        clamp = raw[16] ? 16'h0000 : raw[15:0];
    endfunction

    function automatic logic [CNT_W-1:0] cyc(input int unsigned v);
        cyc = CNT_W'(v);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers and state

    cadc_state_e         state_reg;
    logic [1:0]          cfg_reg;
    logic [15:0]         uv_thr_reg;
    logic [15:0]         ov_thr_reg;
    logic [3:0]          irq_stat_reg;
    logic [3:0]          irq_en_reg;
    logic                ref_up_reg;
    logic                pend_reg;
    cadc_pkg::cadc_cmd_s cmd_reg;
    cadc_pkg::cadc_mode_e mode_reg;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    next_end_reg;
    logic [CNT_W-1:0]    step_reg;
    logic [CNT_W-1:0]    done_tgt_reg;
    logic [2:0]          slot_reg;
    logic [2:0]          nslots_reg;
    logic [3:0]          base_reg;
    logic [NUM_CELLS-1:0] uv_flag_reg;
    logic [NUM_CELLS-1:0] ov_flag_reg;
    logic [15:0]         cell_res_reg [NUM_CELLS];
    logic [15:0]         aux_res_reg  [NUM_AUX];
    logic [15:0]         reg_rdata_reg;

    logic                cmd_take;
    logic                wake_end;
    logic                slot_end;
    logic                conv_start;
    logic                last_slot;
    logic                cal_end;
    logic [3:0]          chan1;
    logic [3:0]          chan2;
    logic                cell_wr;
    logic [15:0]         res1;
    logic [15:0]         res2;
    logic                any_uv;
    logic                any_ov;
    logic [3:0]          irq_set;
    logic [3:0]          irq_clr;
    int unsigned         m_idx;
    int unsigned         cm_idx;

    assign cmd_ready  = (state_reg == CADC_IDLE) ||
                        (state_reg == CADC_WAKE && !pend_reg);
    assign cmd_take   = cmd_valid && cmd_ready;
    assign wake_end   = state_reg == CADC_WAKE && cnt_reg == cyc(REF_WAKE_CYC);
    // Conversion begins at once only if the reference is already up
    assign conv_start = (cmd_take && state_reg == CADC_IDLE && ref_up_reg) ||
                        (wake_end && (pend_reg || cmd_take));    // see [RL4]
    assign slot_end   = state_reg == CADC_MEAS && cnt_reg == next_end_reg;
    assign last_slot  = slot_reg == nslots_reg - 3'h1;
    assign cal_end    = state_reg == CADC_CAL && cnt_reg == done_tgt_reg;
    assign cm_idx     = int'(mode_of(cfg_reg[cadc_pkg::CFG_FILTER_BIT],
                                     cmd_reg.mode));             // see [RL1]
    assign m_idx      = int'(mode_reg);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= CADC_IDLE;
            pend_reg  <= 1'b0;
        end else begin
            unique case (state_reg)
                CADC_IDLE: begin
                    if (cmd_take && !ref_up_reg) begin
                        state_reg <= CADC_WAKE;                  // see [RL4]
                        pend_reg  <= 1'b1;
                    end else if (conv_start) begin
                        state_reg <= CADC_MEAS;                  // see [RL5]
                    end else if (cfg_reg[cadc_pkg::CFG_REF_KEEP_ON_BIT] &&
                                 !ref_up_reg) begin
                        state_reg <= CADC_WAKE;                  // see [RL5]
                        pend_reg  <= 1'b0;
                    end
                end
                CADC_WAKE: begin
                    if (cmd_take) begin
                        pend_reg <= 1'b1;
                    end
                    if (wake_end) begin
                        state_reg <= conv_start ? CADC_MEAS : CADC_IDLE;
                        pend_reg  <= 1'b0;
                    end
                end
                CADC_MEAS: begin
                    if (slot_end && last_slot) begin
                        state_reg <= CADC_CAL;                   // see [RL10]
                    end
                end
                CADC_CAL: begin
                    if (cal_end) begin
                        state_reg <= CADC_IDLE;                  // see [RL10]
                    end
                end
            endcase
        end
    end

    // Latched command; a command taken during an idle warm-up waits here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= '0;
        end else if (cmd_take) begin
            cmd_reg <= cmd;                                      // see [RL8]
        end
    end

    // Reference: up after a wake, kept only while keep-on is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_up_reg <= 1'b0;
        end else if (wake_end) begin
            ref_up_reg <= 1'b1;                                  // see [RL5]
        end else if ((cal_end || state_reg == CADC_IDLE) &&
                     !cfg_reg[cadc_pkg::CFG_REF_KEEP_ON_BIT]) begin
            ref_up_reg <= 1'b0;
        end
    end

    // One counter times wake, slots and calibration
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (conv_start || (cmd_take && !ref_up_reg &&
                     state_reg == CADC_IDLE)) begin
            cnt_reg <= cyc(1);                                   // see [RL18]
        end else if (state_reg == CADC_IDLE && !ref_up_reg &&
                     cfg_reg[cadc_pkg::CFG_REF_KEEP_ON_BIT]) begin
            cnt_reg <= cyc(1);
        end else if (state_reg != CADC_IDLE) begin
            cnt_reg <= cnt_reg + cyc(1);                         // see [RL18]
        end
    end

    // Slot plan is fixed when the conversion starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg     <= cadc_pkg::CADC_M7K;
            nslots_reg   <= 3'h1;
            base_reg     <= 4'h0;
            step_reg     <= '0;
            next_end_reg <= '0;
            done_tgt_reg <= '0;
            slot_reg     <= 3'h0;
        end else if (conv_start) begin
            // Command may still be arriving this cycle when no wake is due
            automatic cadc_pkg::cadc_cmd_s c = pend_reg ? cmd_reg : cmd;
            automatic int unsigned mi = int'(mode_of(
                cfg_reg[cadc_pkg::CFG_FILTER_BIT], c.mode));     // see [RL1]
            automatic logic all = c.chan == 3'h0 || c.chan == 3'h7;
            mode_reg     <= cadc_pkg::cadc_mode_e'(mi[2:0]);     // see [RL2]
            nslots_reg   <= all ? 3'(cadc_pkg::SWEEP_SLOTS)
                                : 3'h1;                          // see [RL16]
            base_reg     <= all ? 4'h0 : {1'b0, c.chan} - 4'h1;
            next_end_reg <= cyc(FIRST_SLOT_CYC[mi]);             // see [RL12]
            step_reg     <= cyc((SWEEP_MEAS_CYC[mi] - FIRST_SLOT_CYC[mi]) /
                                (cadc_pkg::SWEEP_SLOTS - 1));
            done_tgt_reg <= all ? cyc(FULL_DONE_CYC[mi])         // see [RL11]
                                : cyc(PAIR_DONE_CYC[mi]);        // see [RL13]
            slot_reg     <= 3'h0;
        end else if (slot_end) begin
            slot_reg     <= slot_reg + 3'h1;
            next_end_reg <= next_end_reg + step_reg;             // see [RL12]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel routing and results

    always_comb begin
        chan1 = base_reg + {1'b0, slot_reg};                     // see [RL9]
        chan2 = chan1 + 4'h6;                                    // see [RL9]
        if (cmd_reg.aux && chan1 > 4'(NUM_AUX - 1)) begin
            chan1 = 4'(NUM_AUX - 1);                             // see [RL16]
        end
    end

    assign cell_wr = slot_end && !cmd_reg.aux;
    assign res1    = clamp(fe_raw1);                             // see [RL7]
    assign res2    = clamp(fe_raw2);                             // see [RL7]

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CELLS; gi++) begin : g_cell
            logic       hit;
            logic [15:0] val;
            assign hit = cell_wr &&
                         (chan1 == 4'(gi) || chan2 == 4'(gi));   // see [RL19]
            assign val = (chan1 == 4'(gi)) ? res1 : res2;        // see [RL9]
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    cell_res_reg[gi] <= 16'h0000;
                    uv_flag_reg[gi]  <= 1'b0;
                    ov_flag_reg[gi]  <= 1'b0;
                end else if (hit) begin
                    cell_res_reg[gi] <= val;                     // see [RL6]
                    uv_flag_reg[gi]  <= val < uv_thr_reg;        // see [RL14]
                    ov_flag_reg[gi]  <= val > ov_thr_reg;        // see [RL15]
                end
            end
        end
        for (gi = 0; gi < NUM_AUX; gi++) begin : g_aux
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    aux_res_reg[gi] <= 16'h0000;
                end else if (slot_end && cmd_reg.aux &&
                             chan1 == 4'(gi)) begin
                    aux_res_reg[gi] <= res1;                     // see [RL17]
                end
            end
        end
    endgenerate

    // Events from this slot's own samples, not the stored flags
    assign any_uv = cell_wr && (res1 < uv_thr_reg || res2 < uv_thr_reg);
    assign any_ov = cell_wr && (res1 > ov_thr_reg || res2 > ov_thr_reg);

    ////////////////////////////////////////////////////////////////////////
    // Register port

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_reg    <= cadc_pkg::CFG_RST;
            uv_thr_reg <= cadc_pkg::UV_THR_RST;
            ov_thr_reg <= cadc_pkg::OV_THR_RST;
            irq_en_reg <= cadc_pkg::IRQ_EN_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                cadc_pkg::OFS_CFG:    cfg_reg    <= reg_wdata[1:0];
                cadc_pkg::OFS_UV_THR: uv_thr_reg <= reg_wdata;   // see [RL15]
                cadc_pkg::OFS_OV_THR: ov_thr_reg <= reg_wdata;   // see [RL15]
                cadc_pkg::OFS_IRQ_EN: irq_en_reg <= reg_wdata[3:0];
                default: ;
            endcase
        end
    end

    assign irq_clr = (reg_wr && reg_addr == cadc_pkg::OFS_IRQ_CLR)
                     ? reg_wdata[3:0] : 4'h0;

    always_comb begin
        irq_set = 4'h0;
        irq_set[cadc_pkg::IRQ_DONE_BIT]   = cal_end;
        irq_set[cadc_pkg::IRQ_UV_BIT]     = any_uv;
        irq_set[cadc_pkg::IRQ_OV_BIT]     = any_ov;
        irq_set[cadc_pkg::IRQ_REFUSE_BIT] = cmd_valid && !cmd_ready;
    end

    // A new event beats a clear in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_reg <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata_reg <= 16'h0000;
        end else if (reg_addr >= cadc_pkg::OFS_CELL0 &&
                     reg_addr < cadc_pkg::OFS_CELL0 + 8'(NUM_CELLS)) begin
            reg_rdata_reg <= cell_res_reg[4'(reg_addr -
                                             cadc_pkg::OFS_CELL0)];
        end else if (reg_addr >= cadc_pkg::OFS_AUX0 &&
                     reg_addr < cadc_pkg::OFS_AUX0 + 8'(NUM_AUX)) begin
            reg_rdata_reg <= aux_res_reg[3'(reg_addr - cadc_pkg::OFS_AUX0)];
        end else begin
            unique case (reg_addr)
                cadc_pkg::OFS_CFG:      reg_rdata_reg <= {14'h0000, cfg_reg};
                cadc_pkg::OFS_UV_THR:   reg_rdata_reg <= uv_thr_reg;
                cadc_pkg::OFS_OV_THR:   reg_rdata_reg <= ov_thr_reg;
                cadc_pkg::OFS_STATUS:   reg_rdata_reg <= {10'h000,
                                            cmd_reg.aux, mode_reg,
                                            ref_up_reg,
                                            state_reg != CADC_IDLE};
                cadc_pkg::OFS_IRQ_STAT: reg_rdata_reg <= {12'h000,
                                                          irq_stat_reg};
                cadc_pkg::OFS_IRQ_EN:   reg_rdata_reg <= {12'h000,
                                                          irq_en_reg};
                cadc_pkg::OFS_UV_FLAGS: reg_rdata_reg <=
                                            16'(uv_flag_reg);    // see [RL15]
                cadc_pkg::OFS_OV_FLAGS: reg_rdata_reg <=
                                            16'(ov_flag_reg);
                default:                reg_rdata_reg <= 16'h0000;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // Front-end steering

    always_comb begin
        fe             = '0;
        fe.active      = state_reg == CADC_MEAS;
        fe.calibrating = state_reg == CADC_CAL;                  // see [RL10]
        fe.aux         = cmd_reg.aux;
        fe.chan1       = chan1;
        fe.chan2       = cmd_reg.aux ? 4'h0 : chan2;             // see [RL17]
        fe.mode        = mode_reg;                               // see [RL3]
    end

    assign ref_power_on = ref_up_reg || state_reg != CADC_IDLE;

endmodule

// File: cadc_sva.sv
/* Port checker of the conversion sequencer.
   Assumes one clock domain and rst_n active low. */
`timescale 1ns/10ps
module cadc_sva (
    input wire logic               clk,
    input wire logic               rst_n,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    input wire logic               cmd_valid,
    input wire logic               cmd_ready,
    input wire cadc_pkg::cadc_fe_s fe,
    input wire logic               ref_power_on
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("rdata without read");
    property p_take; cmd_valid && cmd_ready |=> !cmd_ready; endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_warm; cmd_valid && cmd_ready && ref_power_on |=> fe.active; endproperty
    a_warm: assert property (p_warm) else $error("warm start late");
    property p_cold; cmd_valid && cmd_ready && !ref_power_on |=> !fe.active [*8]; endproperty
    a_cold: assert property (p_cold) else $error("cold start early");
    property p_ref; fe.active || fe.calibrating |-> ref_power_on; endproperty
    a_ref: assert property (p_ref) else $error("convert without ref");
    property p_cal; fe.calibrating |-> !fe.active; endproperty
    a_cal: assert property (p_cal) else $error("cal during measure");
    property p_end; $fell(fe.calibrating) |-> ##[0:1] cmd_ready; endproperty
    a_end: assert property (p_end) else $error("no ready after cal");
    property p_mode; fe.active && $past(fe.active) |-> $stable(fe.mode); endproperty
    a_mode: assert property (p_mode) else $error("mode moved");
endmodule
bind cadc_sequencer cadc_sva u_cadc_sva (.clk, .rst_n, .reg_rd, .reg_rdata,
    .cmd_valid, .cmd_ready, .fe, .ref_power_on);

// File: cadc_fe_model.sv
/* Converter front-end model: one sample per selected channel.
   Assumes fe comes from the sequencer on clk. */
`timescale 1ns/10ps
module cadc_fe_model (
    input  wire logic               clk,
    input  wire cadc_pkg::cadc_fe_s fe,
    input  wire logic signed [16:0] bias,
    output logic signed [16:0]      fe_raw1,
    output logic signed [16:0]      fe_raw2
);
    logic signed [16:0] junk = 17'sh0AAAA;
    // Idle lines toggle so a stale sample never passes for data
    always @(posedge clk) junk <= ~junk;
    // Channel c reads c*300-5 plus bias; channel 0 reads negative while bias is below 5
    always_comb begin
        fe_raw1 = fe.active ? $signed({13'h0000, fe.chan1}) * 17'sh0012C
                  - 17'sh00005 + bias : junk;
        fe_raw2 = fe.active ? $signed({13'h0000, fe.chan2}) * 17'sh0012C
                  - 17'sh00005 + bias : junk;
    end
endmodule

// File: tb_cadc_sequencer.sv
/* Bench of the conversion sequencer: timing, wake, results, flags, irq.
   Assumes the front-end model and a 40 MHz clock. */
`timescale 1ns/10ps
module tb_cadc_sequencer;
    localparam cadc_pkg::cadc_tab_t FULL = '{200, 210, 220, 230, 240, 250};
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic cmd_valid = 1'b0, cmd_ready, ref_power_on, irq;
    logic [7:0]          reg_addr = 8'h00;
    logic [15:0]         reg_wdata = 16'h0000, reg_rdata, d;
    cadc_pkg::cadc_cmd_s cmd = '0;
    cadc_pkg::cadc_fe_s  fe;
    logic signed [16:0]  fe_raw1, fe_raw2, bias = 17'sh00000;
    int                  fail_count = 0, compares = 0, cyc = 0, n;
    always #12.5 clk = ~clk;
    cadc_sequencer #(.FIRST_SLOT_CYC('{6{20}}), .SWEEP_MEAS_CYC('{6{70}}),
        .FULL_DONE_CYC(FULL), .PAIR_DONE_CYC('{6{60}}), .REF_WAKE_CYC(10))
        u_cadc_sequencer (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cmd_valid, .cmd, .cmd_ready, .fe_raw1,
        .fe_raw2, .fe, .ref_power_on, .irq);
    cadc_fe_model u_cadc_fe_model (.clk, .fe, .bias, .fe_raw1, .fe_raw2);
    function automatic logic [15:0] ex(input int c, input int b);
        return (c * 300 - 5 + b < 0) ? 16'h0000 : 16'(c * 300 - 5 + b);
    endfunction
    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] w);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic go(input logic x, input logic [1:0] m, input logic [2:0] c);
        @(posedge clk);
        {cmd_valid, cmd} <= {1'b1, x, m, c};
        @(posedge clk);
        cmd_valid <= 1'b0;
    endtask
    task automatic run(input logic [5:0] xmc, input int em, input int t);
        go(xmc[5], xmc[4:3], xmc[2:0]);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
            if (fe.active) chk("fe.mode", 16'(em), 16'(fe.mode));
        end while (irq !== 1'b1 && n < 1000);
        chk("done cycles", 16'(t), 16'(n));
        wr(8'h06, 16'h0001);
    endtask
    task automatic t_wake; // cold start waits, keep-on skips the wait
        run(6'h09, 0, 70);
        wr(8'h00, 16'h0002);
        repeat (12) @(posedge clk);
        #1 chk("ref up", 16'h0001, 16'(ref_power_on));
        run(6'h09, 0, 60);
    endtask
    task automatic t_modes;
        for (int i = 0; i < 6; i++) begin
            wr(8'h00, {14'h0000, 1'b1, 1'(6'h1A >> i)});
            run({1'b0, 2'(i / 2 + 1), 3'h0}, i, FULL[i]);
        end
        wr(8'h00, 16'h0002);
        run(6'h00, 2, FULL[2]);
    endtask
    task automatic t_data;
        for (int k = 0; k < 12; k++) begin
            rd(8'(8'h10 + k));
            chk("cell", ex(k, 0), d);
        end
        rd(8'h07);
        chk("uv flags", 16'h000F, d);
        rd(8'h08);
        chk("ov flags", 16'h0E00, d);
    endtask
    task automatic t_aux; // aux sweep must leave cell flags alone
        bias <= 17'sh00064;
        run(6'h28, 0, FULL[0]);
        for (int k = 0; k < 6; k++) begin
            rd(8'(8'h20 + k));
            chk("aux", ex(k, 100), d);
        end
        rd(8'h07);
        chk("uv kept", 16'h000F, d);
    endtask
    task automatic t_pair;
        bias <= 17'sh001F4;
        run(6'h0A, 0, 60);
        for (int k = 0; k < 12; k++) begin
            rd(8'(8'h10 + k));
            chk("cell", (k == 1 || k == 7) ? ex(k, 500) : ex(k, 0), d);
        end
        rd(8'h08);
        chk("ov flags", 16'h0E80, d);
    endtask
    task automatic t_irq; // masked done, refused command, unmask, clear
        wr(8'h05, 16'h0000);
        go(1'b0, 2'h1, 3'h1);
        go(1'b0, 2'h1, 3'h1);
        repeat (62) @(posedge clk);
        #1 chk("irq masked", 16'h0000, 16'(irq));
        rd(8'h04);
        chk("irq stat", 16'h0009, d & 16'h0009);
        wr(8'h05, 16'h0001);
        #1 chk("irq on", 16'h0001, 16'(irq));
        wr(8'h06, 16'h000F);
        #1 chk("irq clr", 16'h0000, 16'(irq));
    endtask
    task automatic end_of_test;
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            end_of_test;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wr(8'h01, 16'h03E8);
        wr(8'h02, 16'h09C4);
        wr(8'h05, 16'h0001);
        t_wake;
        t_modes;
        t_data;
        t_aux;
        t_pair;
        t_irq;
        end_of_test;
    end
endmodule
